// *** host_model.sv ***
// Purpose: host side, one command per call
// Assumes: results settle before return, except the saved mask, which settles one cycle later
// Notes:   index is released as its inverse
module host_model (
   input  wire       clk,  // Clock
   output reg        vld,  // Strobe
   output reg  [2:0] op,   // Code
   output reg        hidx, // Index given
   output reg  [7:0] arg   // Index or mask
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {vld, op, hidx, arg} = 13'h0000;
   // Strobe one cycle, then one idle cycle
   task send(input [2:0] o, input [7:0] a, input h);
      @(negedge clk);
      {vld, op, arg, hidx} <= {1'b1, o, a, h};
      @(negedge clk);
      {vld, arg} <= {1'b0, ~a};
      @(negedge clk);
   endtask
endmodule

// *** shutter_chk_sva.sv ***
// Purpose: port checks for the shutter block
// Assumes: one clock, sync reset
// Notes:   bound by port names
module shutter_chk #(parameter NCARDS = 4) (
   input wire I_MCLK, I_SRST, i_cmd_valid, i_cmd_has_idx, o_status_valid, o_save_done, // Controls
   input wire [2:0] i_cmd_op, // Code
   input wire [7:0] i_cmd_arg, o_status, o_mask, o_saved_mask, o_coil_energize, // Data
   input wire [NCARDS-1:0] i_card_present // Cards
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_SRST);
   // Query, open or close taken, shutter number
   wire q = i_cmd_valid && i_cmd_op == 3'h3;
   wire oc = i_cmd_valid && (i_cmd_op == 3'h1 || i_cmd_op == 3'h2);
   wire [2:0] k = i_cmd_arg[2:0];
   // Mask as the commands set it, kept here so coil checks see it at the command edge
   reg  [7:0] mdl_mask;
   always @(posedge I_MCLK) begin
      if (I_SRST) mdl_mask <= 8'h00;
      else if (i_cmd_valid && i_cmd_op == 3'h4) mdl_mask <= i_cmd_arg;
      else if (i_cmd_valid && i_cmd_op == 3'h6) mdl_mask <= 8'h00;
   end
   sequence s_save; i_cmd_valid && i_cmd_op == 3'h5 ##1 1'b1; endsequence
   property p_qv; q |=> o_status_valid; endproperty
   a_qv: assert property (p_qv) else $error("no answer");
   property p_hi; o_status_valid |-> o_status[7:5] == 3'h0; endproperty
   a_hi: assert property (p_hi) else $error("high bits");
   property p_sd; s_save |=> o_save_done; endproperty
   a_sd: assert property (p_sd) else $error("no save done");
   property p_sm; s_save |=> ##1 o_saved_mask == $past(o_mask, 2); endproperty
   a_sm: assert property (p_sm) else $error("saved mask");
   property p_df; i_cmd_valid && i_cmd_op == 3'h6 |=> ##1 o_mask == 8'h00; endproperty
   a_df: assert property (p_df) else $error("default mask");
   property p_cl; oc && i_cmd_arg < 8'h08 && i_card_present[k[2:1]] |=>
      o_coil_energize[$past(k)] == ($past(i_cmd_op == 3'h2) ^ $past(mdl_mask[k])); endproperty
   a_cl: assert property (p_cl) else $error("coil drive");
   property p_mk; o_mask == $past(mdl_mask); endproperty
   a_mk: assert property (p_mk) else $error("working mask");
   property p_or; oc && i_cmd_arg > 8'h07 |=> $stable(o_coil_energize); endproperty
   a_or: assert property (p_or) else $error("range");
   property p_pr; q && i_cmd_has_idx |=> o_status[4] == $past(i_card_present[k[2:1]]); endproperty
   a_pr: assert property (p_pr) else $error("presence");
endmodule
bind shutter_command_status shutter_chk #(.NCARDS(NCARDS)) u_chk (.*);

// *** shutter_command_status.v ***
// Purpose: shutter open/close/query/mask command executor with status byte
// Assumes: commands arrive as one-cycle strobes with a 3-bit code decoded here; card inputs synchronous
// Notes:   two shutters per card; coil outputs one bit per shutter
module shutter_command_status #(
   parameter NCARDS = 4,                 // Card slots
   parameter NSH    = 8,                 // Shutters (two per card, mask width)
   parameter IW     = 3,                 // Index width
   parameter CW     = 2                  // Card index width
) (
   input  wire            I_MCLK,        // System clock, 200 MHz
   input  wire            I_SRST,        // Synchronous reset, active high
   input  wire            i_cmd_valid,   // Command strobe
   input  wire [2:0]      i_cmd_op,      // Command code
   input  wire            i_cmd_has_idx, // Index argument present
   input  wire [7:0]      i_cmd_arg,     // Index or mask value
   input  wire [NCARDS-1:0] i_card_present, // Card installed and responding
   input  wire [NSH-1:0]  i_sens_fitted, // Position sensor fitted
   input  wire [NSH-1:0]  i_sens_open,   // Sensor reports open
   output reg  [NSH-1:0]  o_coil_energize, // Coil drive per shutter
   output reg  [7:0]      o_status,      // Query answer byte
   output reg             o_status_valid, // Query answer strobe
   output reg  [7:0]      o_mask,        // Current polarity mask
   output reg  [7:0]      o_saved_mask,  // Mask held in flash
   output reg             o_save_done    // Save completed strobe
);
`include "shutter_map.vh"

   // Command strobes, one per code
   wire           cmd_open;       // Open request taken this edge
   wire           cmd_close;      // Close request taken this edge
   wire           cmd_query;      // Status request taken this edge
   wire           cmd_set_mask;   // Mask load taken this edge
   wire           cmd_defaults;   // Defaults restore taken this edge
   wire           cmd_save;       // Parameter save taken this edge

   // Shutter index and its acceptance
   wire [IW-1:0]  idx;            // Shutter number carried by the argument
   wire [CW-1:0]  idx_card;       // Card that serves that shutter
   wire           idx_in_range;   // Argument names an existing slot
   wire           idx_ok;         // Slot exists and its card answers
   wire           drive_req;      // Accepted open or close
   wire [NSH-1:0] idx_onehot;     // One bit per shutter, set for the target

   // Working state and next values
   reg  [7:0]     mask_r;         // Working polarity mask, set bit = normally closed
   reg  [7:0]     mask_nxt;       // Mask after this edge
   reg  [CW-1:0]  last_card_r;    // Card of the last accepted open or close
   reg  [CW-1:0]  last_card_nxt;  // Card after this edge
   reg            save_pend_r;    // Save taken, done strobe follows
   wire [NSH-1:0] coil_nxt;       // Coil drive after this edge
   wire [7:0]     nv_rdata;       // Stored mask read back

   // Query path
   reg  [CW-1:0]  q_card;         // Card whose status is reported
   reg  [7:0]     q_byte;         // Status byte of that card

   // Card number serving a shutter index
   function [CW-1:0] card_of;
      input [7:0] a;
      begin
         card_of = a[CW:1];
      end
   endfunction

   // Coil level for an open or close: a set mask bit swaps the sense
   function coil_level;
      input close_req;            // High for close, low for open
      input nc_bit;               // Polarity mask bit of the shutter
      begin
         coil_level = close_req ^ nc_bit;
      end
   endfunction

   // Position bit: high when closed or when no sensor can tell
   function closed_or_blind;
      input fitted;               // Sensor present
      input seen_open;            // Sensor reports open
      begin
         closed_or_blind = ~(fitted & seen_open);
      end
   endfunction

   // Decode the code of a taken command; unknown codes do nothing
   assign cmd_open     = i_cmd_valid && (i_cmd_op == `CMD_OPEN);
   assign cmd_close    = i_cmd_valid && (i_cmd_op == `CMD_CLOSE);
   assign cmd_query    = i_cmd_valid && (i_cmd_op == `CMD_QUERY);
   assign cmd_set_mask = i_cmd_valid && (i_cmd_op == `CMD_SET_MASK);
   assign cmd_defaults = i_cmd_valid && (i_cmd_op == `CMD_DEFAULTS);
   assign cmd_save     = i_cmd_valid && (i_cmd_op == `CMD_SAVE);

   // Index check: the slot must exist and its card must answer
   assign idx          = i_cmd_arg[IW-1:0];
   assign idx_card     = card_of(i_cmd_arg);
   assign idx_in_range = (i_cmd_arg < NSH);
   assign idx_ok       = idx_in_range && i_card_present[idx_card];
   assign drive_req    = (cmd_open || cmd_close) && idx_ok;
   assign idx_onehot   = {{(NSH-1){1'b0}}, 1'b1} << idx;

   // Per-shutter coil next value: only the accepted target moves
   genvar g;
   generate
      for (g = 0; g < NSH; g = g + 1) begin : g_coil
         wire hit;                // This shutter is the accepted target
         assign hit         = drive_req & idx_onehot[g];
         assign coil_nxt[g] = hit ? coil_level(cmd_close, mask_r[g])
                                  : o_coil_energize[g];
      end
   endgenerate

   // Status byte of the selected card; an absent card reads as zero
   always @* begin
      q_card = i_cmd_has_idx ? card_of(i_cmd_arg) : last_card_r;
      q_byte = `STATUS_NONE;
      if (i_card_present[q_card]) begin
         q_byte[`ST_DEENERG0] = ~o_coil_energize[{q_card, 1'b0}];
         q_byte[`ST_DEENERG1] = ~o_coil_energize[{q_card, 1'b1}];
         q_byte[`ST_CLOSED0]  = closed_or_blind(i_sens_fitted[{q_card, 1'b0}],
                                                i_sens_open[{q_card, 1'b0}]);
         q_byte[`ST_CLOSED1]  = closed_or_blind(i_sens_fitted[{q_card, 1'b1}],
                                                i_sens_open[{q_card, 1'b1}]);
         q_byte[`ST_PRESENT]  = 1'b1;
         q_byte[`ST_ZERO_HI:`ST_ZERO_LO] = `ST_ZERO_BITS;
      end
   end

   // Coil drive register; reset leaves every shutter in its normal state
   always @(posedge I_MCLK) begin
      if (I_SRST) begin
         o_coil_energize <= {NSH{1'b0}};
      end else begin
         o_coil_energize <= coil_nxt;
      end
   end

   // Next mask: load wins over restore, otherwise hold
   always @* begin
      mask_nxt = mask_r;
      if (cmd_set_mask) begin
         mask_nxt = i_cmd_arg;
      end else if (cmd_defaults) begin
         mask_nxt = `MASK_RESET;
      end
   end

   // Working polarity mask
   always @(posedge I_MCLK) begin
      if (I_SRST) begin
         mask_r <= `MASK_RESET;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // Next card for an unqualified query: only accepted drives move it
   always @* begin
      last_card_nxt = last_card_r;
      if (drive_req) begin
         last_card_nxt = idx_card;
      end
   end

   // Last addressed card; starts at the card of shutters 0 and 1
   always @(posedge I_MCLK) begin
      if (I_SRST) begin
         last_card_r <= {CW{1'b0}};
      end else begin
         last_card_r <= last_card_nxt;
      end
   end

   // Query answer, held until the next query, and its one-cycle strobe
   always @(posedge I_MCLK) begin
      if (I_SRST) begin
         o_status       <= `STATUS_NONE;
         o_status_valid <= 1'b0;
      end else begin
         o_status_valid <= cmd_query;
         if (cmd_query) begin
            o_status <= q_byte;
         end
      end
   end

   // Save strobe chain: done pulses one edge after the save is taken
   always @(posedge I_MCLK) begin
      if (I_SRST) begin
         save_pend_r <= 1'b0;
         o_save_done <= 1'b0;
      end else begin
         save_pend_r <= cmd_save;
         o_save_done <= save_pend_r;
      end
   end

   // Mirror mask and stored copy onto outputs
   always @(posedge I_MCLK) begin
      if (I_SRST) begin
         o_mask       <= `MASK_RESET;
         o_saved_mask <= `MASK_RESET;
      end else begin
         o_mask       <= mask_r;
         o_saved_mask <= nv_rdata;
      end
   end

   // Flash copy of working parameters; the stored copy shows two edges later
   shutter_nv_store #(.WIDTH(8)) u_nv (
      .clk   (I_MCLK),
      .we    (cmd_save),
      .wdata (mask_r),
      .rdata (nv_rdata)
   );
endmodule

// *** shutter_map.vh ***
`ifndef SHUTTER_MAP_VH
`define SHUTTER_MAP_VH
// Purpose: constants for the shutter command and status block
// Assumes: one clock, synchronous active-high reset
// Notes:   command codes are carried on a 3-bit opcode port
`define CMD_OPEN       3'h1
`define CMD_CLOSE      3'h2
`define CMD_QUERY      3'h3
`define CMD_SET_MASK   3'h4
`define CMD_SAVE       3'h5
`define CMD_DEFAULTS   3'h6
`define MASK_RESET     8'h00
`define ST_DEENERG0    0
`define ST_DEENERG1    1
`define ST_CLOSED0     2
`define ST_CLOSED1     3
`define ST_PRESENT     4
`define ST_ZERO_BITS   3'h0
`define ST_ZERO_HI     7
`define ST_ZERO_LO     5
`define STATUS_NONE    8'h00
`endif

// *** shutter_nv_store.v ***
// Purpose: non-volatile parameter store holding the saved polarity mask
// Assumes: write strobe one cycle; read data registered
// Notes:   models the flash word that keeps the mask
module shutter_nv_store #(
   parameter WIDTH = 8
) (
   input  wire             clk,     // System clock
   input  wire             we,      // Save strobe
   input  wire [WIDTH-1:0] wdata,   // Value to store
   output reg  [WIDTH-1:0] rdata    // Stored value
);
   reg [WIDTH-1:0] mem_r;

   // Store on save, read out through a register
   always @(posedge clk) begin
      if (we) begin
         mem_r <= wdata;
      end
      rdata <= mem_r;
   end
endmodule

// *** tb_top.sv ***
// Purpose: directed shutter command tests
// Assumes: host model spaces commands
// Notes:   checks follow each settled command
`include "shutter_map.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   reg        I_MCLK = 1'b0, I_SRST = 1'b1;
   reg  [3:0] i_card_present = 4'hf;
   reg  [7:0] i_sens_fitted = 8'h00, i_sens_open = 8'h00;
   wire       i_cmd_valid, i_cmd_has_idx, o_status_valid, o_save_done;
   wire [2:0] i_cmd_op;
   wire [7:0] i_cmd_arg, o_coil_energize, o_status, o_mask, o_saved_mask;
   integer    errors = 0, cmp_count = 0, cyc = 0, n;
   always #2.5 I_MCLK = ~I_MCLK;
   host_model hm (.clk(I_MCLK), .vld(i_cmd_valid), .op(i_cmd_op), .hidx(i_cmd_has_idx), .arg(i_cmd_arg));
   shutter_command_status dut (.*);
   // Counts and verdict
   task end_sim;
      $display("cmp %0d err %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge I_MCLK) if (++cyc == 2000) begin
      errors++;
      end_sim;
   end
   // Test sequence
   initial begin
      repeat (10) @(negedge I_MCLK);
      I_SRST = 1'b0;
      `CHK("reset coil", 8'h00, o_coil_energize)
      `CHK("reset mask", 8'h00, o_mask)
      hm.send(`CMD_QUERY, 8'h00, 1'b0);
      `CHK("status", 8'h1f, o_status)
      $display("test reset and first query done");
      for (n = 0; n < 8; n++) begin
         hm.send(`CMD_CLOSE, n[7:0], 1'b0);
         `CHK("close", 8'h01 << n, o_coil_energize)
         hm.send(`CMD_OPEN, n[7:0], 1'b0);
         `CHK("open", 8'h00, o_coil_energize)
      end
      $display("test open and close done");
      hm.send(`CMD_SET_MASK, 8'h0a, 1'b0);
      `CHK("mask", 8'h0a, o_mask)
      {i_sens_fitted[3], i_sens_open[3]} = 2'b11;
      hm.send(`CMD_OPEN, 8'h03, 1'b0);
      `CHK("open nc", 8'h08, o_coil_energize)
      hm.send(`CMD_QUERY, 8'h00, 1'b0);
      `CHK("last card", 8'h15, o_status)
      hm.send(`CMD_OPEN, 8'h08, 1'b0);
      `CHK("range", 8'h08, o_coil_energize)
      $display("test polarity mask done");
      hm.send(`CMD_SAVE, 8'h00, 1'b0);
      `CHK("save done", 1'b1, o_save_done)
      @(negedge I_MCLK);
      `CHK("saved", 8'h0a, o_saved_mask)
      hm.send(`CMD_DEFAULTS, 8'h00, 1'b0);
      `CHK("default", 8'h00, o_mask)
      $display("test save and defaults done");
      i_card_present[3] = 1'b0;
      hm.send(`CMD_QUERY, 8'h06, 1'b1);
      `CHK("absent", 8'h00, o_status)
      $display("test absent card done");
      end_sim;
   end
endmodule
